/* hdl/fcf_map.svh */
// Constants for the FIFO configuration and flag control block
`ifndef FCF_MAP_SVH
`define FCF_MAP_SVH

// ******************************
// Storage geometry
// ******************************
`define FCF_DATA_W 18
`define FCF_ADDR_W 4
`define FCF_PTR_W 5
`define FCF_DEPTH 5'h10
`define FCF_BUF_DEPTH 2'h2

// ******************************
// Offsets
// ******************************
`define FCF_OFF_W 5
`define FCF_SHIFT_W 10
`define FCF_OFF_RESET 5'h01
`define FCF_DEF_OFF_0 5'h01
`define FCF_DEF_OFF_1 5'h02
`define FCF_DEF_OFF_2 5'h03
`define FCF_DEF_OFF_3 5'h04
`define FCF_DEF_OFF_4 5'h05
`define FCF_DEF_OFF_5 5'h06
`define FCF_DEF_OFF_6 5'h07
`define FCF_DEF_OFF_7 5'h08

// ******************************
// Word masks
// ******************************
`define FCF_MASK_X18 18'h3ffff
`define FCF_MASK_X9 18'h001ff

`endif

/* hdl/fcf_pkg.sv */
// Types for the FIFO configuration and flag control block
`default_nettype none
package fcf_pkg;

  // Port width pairing, write side then read side
  typedef enum logic [3:0] {
    FCF_X18_X18 = 4'h1,
    FCF_X18_X9 = 4'h2,
    FCF_X9_X18 = 4'h4,
    FCF_X9_X9 = 4'h8
  } fcf_bus_t;

  typedef struct packed {
    logic fallthrough;
    logic parity_interspersed;
    logic flag_sync;
    logic serial_prog;
    logic little_endian;
    logic read_sync;
    logic write_sync;
    logic zero_latency;
    logic [2:0] default_sel;
    fcf_bus_t bus;
  } fcf_cfg_t;

  typedef struct packed {
    logic parity_layout_strap;
    logic write_width_strap;
    logic read_width_strap;
    logic flag_timing_strap;
    logic offset_default_select_0;
    logic offset_default_select_1;
    logic endian_strap;
    logic read_sync_strap;
    logic write_sync_strap;
    logic zero_latency_strap;
  } fcf_straps_t;

endpackage
`default_nettype wire

/* hdl/fcf_flag_control.sv */
// FIFO configuration capture, offset registers, mark/retransmit and flags
`timescale 1ns/1ps
`default_nettype none
`include "fcf_map.svh"

module fcf_flag_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic master_clear_n,
  input wire logic partial_clear_n,
  input wire fcf_pkg::fcf_straps_t straps,
  input wire logic offset_load_select_n,
  input wire logic first_word_fallthrough_si,
  input wire logic offset_shift_enable_n,
  input wire logic offset_shift_clock,
  input wire logic write_en,
  input wire logic [`FCF_DATA_W-1:0] write_data,
  output logic write_ready,
  input wire logic read_en,
  output logic read_valid,
  input wire logic read_ready,
  output logic [`FCF_DATA_W-1:0] read_data,
  input wire logic output_enable_n,
  output logic read_data_oe,
  input wire logic mark,
  input wire logic retransmit_request_n,
  output logic empty_indication_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output fcf_pkg::fcf_cfg_t cfg
);

  // ******************************
  // Decoding helpers
  // ******************************
  function automatic fcf_pkg::fcf_bus_t bus_decode(input logic iw, input logic ow);
    unique case ({iw, ow})
      2'b00: bus_decode = fcf_pkg::FCF_X18_X18;
      2'b01: bus_decode = fcf_pkg::FCF_X18_X9;
      2'b10: bus_decode = fcf_pkg::FCF_X9_X18;
      default: bus_decode = fcf_pkg::FCF_X9_X9;
    endcase
  endfunction

  function automatic logic [`FCF_DATA_W-1:0] width_mask(input logic is_x9);
    width_mask = is_x9 ? `FCF_MASK_X9 : `FCF_MASK_X18;
  endfunction

  function automatic logic [`FCF_OFF_W-1:0] default_offset(input logic [2:0] sel);
    unique case (sel)
      3'h0: default_offset = `FCF_DEF_OFF_0;
      3'h1: default_offset = `FCF_DEF_OFF_1;
      3'h2: default_offset = `FCF_DEF_OFF_2;
      3'h3: default_offset = `FCF_DEF_OFF_3;
      3'h4: default_offset = `FCF_DEF_OFF_4;
      3'h5: default_offset = `FCF_DEF_OFF_5;
      3'h6: default_offset = `FCF_DEF_OFF_6;
      default: default_offset = `FCF_DEF_OFF_7;
    endcase
  endfunction

  // ******************************
  // Declarations
  // ******************************
  fcf_pkg::fcf_cfg_t cfg_reg;
  logic in_master, in_clear;
  logic [2:0] sel_now;
  logic write_x9, read_x9;
  logic [`FCF_DATA_W-1:0] mem_reg [`FCF_DEPTH];
  logic [`FCF_PTR_W-1:0] wr_ptr_reg, rd_ptr_reg, mark_ptr_reg, count;
  logic mark_valid_reg;
  logic [`FCF_OFF_W-1:0] empty_off_reg, full_off_reg;
  logic off_wr_sel_reg, off_rd_sel_reg;
  logic shift_clk_reg;
  logic mem_full, mem_empty, mem_write, mem_read, off_read, rt;
  logic [`FCF_DATA_W-1:0] buf_reg [2];
  logic [1:0] buf_cnt_reg;
  logic buf_in_valid, buf_in_ready, buf_pop;
  logic [`FCF_DATA_W-1:0] buf_in_data;
  logic rt_empty_reg;
  logic ae_comb, af_comb, ae_reg, af_reg;

  assign in_master = ~master_clear_n;
  assign in_clear = ~master_clear_n | ~partial_clear_n;
  assign sel_now = {offset_load_select_n, straps.offset_default_select_1,
                    straps.offset_default_select_0};
  assign rt = ~retransmit_request_n & ~in_clear;

  // ******************************
  // Configuration capture
  // ******************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_reg <= '{fallthrough: 1'b0, parity_interspersed: 1'b0, flag_sync: 1'b0,
                   serial_prog: 1'b0, little_endian: 1'b0, read_sync: 1'b0,
                   write_sync: 1'b0, zero_latency: 1'b0, default_sel: 3'h0,
                   bus: fcf_pkg::FCF_X18_X18};
    end else if (in_master) begin
      cfg_reg.fallthrough <= first_word_fallthrough_si;
      cfg_reg.parity_interspersed <= straps.parity_layout_strap;
      cfg_reg.flag_sync <= straps.flag_timing_strap;
      cfg_reg.serial_prog <= ~offset_load_select_n;
      cfg_reg.little_endian <= straps.endian_strap;
      cfg_reg.read_sync <= straps.read_sync_strap;
      cfg_reg.write_sync <= straps.write_sync_strap;
      cfg_reg.zero_latency <= straps.zero_latency_strap;
      cfg_reg.default_sel <= sel_now;
      cfg_reg.bus <= bus_decode(straps.write_width_strap, straps.read_width_strap);
    end
  end

  assign cfg = cfg_reg;
  // Write side is x9 for the two modes that start with x9, read side for those ending in x9
  assign write_x9 = (cfg_reg.bus == fcf_pkg::FCF_X9_X18) | (cfg_reg.bus == fcf_pkg::FCF_X9_X9);
  assign read_x9 = (cfg_reg.bus == fcf_pkg::FCF_X18_X9) | (cfg_reg.bus == fcf_pkg::FCF_X9_X9);

  // ******************************
  // Offset registers
  // ******************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift_clk_reg <= 1'b0;
    end else begin
      shift_clk_reg <= offset_shift_clock;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      empty_off_reg <= `FCF_OFF_RESET;
      full_off_reg <= `FCF_OFF_RESET;
      off_wr_sel_reg <= 1'b0;
    end else if (in_master) begin
      empty_off_reg <= default_offset(sel_now);
      full_off_reg <= default_offset(sel_now);
      off_wr_sel_reg <= 1'b0;
    end else if (cfg_reg.serial_prog) begin
      // Serial chain runs empty offset first, full offset last
      if (~offset_shift_enable_n & offset_shift_clock & ~shift_clk_reg) begin
        {empty_off_reg, full_off_reg} <=
          {empty_off_reg[`FCF_OFF_W-2:0], full_off_reg, first_word_fallthrough_si};
      end
    end else if (~offset_load_select_n & write_en & ~in_clear) begin
      if (off_wr_sel_reg) begin
        full_off_reg <= write_data[`FCF_OFF_W-1:0];
      end else begin
        empty_off_reg <= write_data[`FCF_OFF_W-1:0];
      end
      off_wr_sel_reg <= ~off_wr_sel_reg;
    end
  end

  // ******************************
  // Storage and pointers
  // ******************************
  assign count = wr_ptr_reg - rd_ptr_reg;
  assign mem_full = (count == `FCF_DEPTH);
  assign mem_empty = (count == {`FCF_PTR_W{1'b0}});
  assign write_ready = ~mem_full & offset_load_select_n & ~in_clear;
  assign mem_write = write_en & write_ready;
  assign mem_read = buf_in_ready & ~mem_empty & ~rt & ~in_clear & offset_load_select_n &
                    (cfg_reg.fallthrough | read_en);
  assign off_read = buf_in_ready & read_en & ~offset_load_select_n & ~in_clear;

  genvar gi;
  generate
    for (gi = 0; gi < `FCF_DEPTH; gi++) begin : g_mem
      always_ff @(posedge clk_sys) begin
        if (mem_write && wr_ptr_reg[`FCF_ADDR_W-1:0] == `FCF_ADDR_W'(gi)) begin
          mem_reg[gi] <= write_data & width_mask(write_x9);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= {`FCF_PTR_W{1'b0}};
    end else if (in_clear) begin
      wr_ptr_reg <= {`FCF_PTR_W{1'b0}};
    end else if (mem_write) begin
      wr_ptr_reg <= wr_ptr_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_ptr_reg <= {`FCF_PTR_W{1'b0}};
    end else if (in_clear) begin
      rd_ptr_reg <= {`FCF_PTR_W{1'b0}};
    end else if (rt) begin
      rd_ptr_reg <= mark_valid_reg ? mark_ptr_reg : {`FCF_PTR_W{1'b0}};
    end else if (mem_read) begin
      rd_ptr_reg <= rd_ptr_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mark_ptr_reg <= {`FCF_PTR_W{1'b0}};
      mark_valid_reg <= 1'b0;
    end else if (in_clear) begin
      mark_valid_reg <= 1'b0;
    end else if (mark) begin
      mark_ptr_reg <= rd_ptr_reg;
      mark_valid_reg <= 1'b1;
    end
  end

  // ******************************
  // Two-entry output buffer
  // ******************************
  always_comb begin
    buf_in_valid = mem_read | off_read;
    buf_in_data = {`FCF_DATA_W{1'b0}};
    if (mem_read) begin
      buf_in_data = mem_reg[rd_ptr_reg[`FCF_ADDR_W-1:0]] & width_mask(read_x9);
    end else if (off_read) begin
      buf_in_data[`FCF_OFF_W-1:0] = off_rd_sel_reg ? full_off_reg : empty_off_reg;
    end
  end

  assign buf_in_ready = (buf_cnt_reg != `FCF_BUF_DEPTH) | buf_pop;
  assign read_valid = (buf_cnt_reg != 2'h0);
  assign buf_pop = read_valid & read_ready;
  assign read_data = buf_reg[0];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      off_rd_sel_reg <= 1'b0;
    end else if (in_clear) begin
      off_rd_sel_reg <= 1'b0;
    end else if (off_read) begin
      off_rd_sel_reg <= ~off_rd_sel_reg;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      buf_reg[0] <= {`FCF_DATA_W{1'b0}};
      buf_reg[1] <= {`FCF_DATA_W{1'b0}};
      buf_cnt_reg <= 2'h0;
    end else if (in_clear) begin
      buf_reg[0] <= {`FCF_DATA_W{1'b0}};
      buf_reg[1] <= {`FCF_DATA_W{1'b0}};
      buf_cnt_reg <= 2'h0;
    end else begin
      unique case ({buf_in_valid, buf_pop})
        2'b10: begin
          if (buf_cnt_reg == 2'h0) begin
            buf_reg[0] <= buf_in_data;
          end else begin
            buf_reg[1] <= buf_in_data;
          end
          buf_cnt_reg <= buf_cnt_reg + 2'h1;
        end
        2'b01: begin
          buf_reg[0] <= buf_reg[1];
          buf_cnt_reg <= buf_cnt_reg - 2'h1;
        end
        2'b11: begin
          if (buf_cnt_reg == 2'h1) begin
            buf_reg[0] <= buf_in_data;
          end else begin
            buf_reg[0] <= buf_reg[1];
            buf_reg[1] <= buf_in_data;
          end
        end
        default: begin
          buf_cnt_reg <= buf_cnt_reg;
        end
      endcase
    end
  end

  // Three-state control follows the pin with no clock in the path
  assign read_data_oe = ~output_enable_n;

  // ******************************
  // Status flags
  // ******************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rt_empty_reg <= 1'b0;
    end else begin
      rt_empty_reg <= rt;
    end
  end

  assign empty_indication_n = ~mem_empty & ~rt & ~rt_empty_reg & ~in_clear;

  assign ae_comb = (count >= empty_off_reg);
  assign af_comb = ((`FCF_DEPTH - count) > full_off_reg);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ae_reg <= 1'b0;
      af_reg <= 1'b1;
    end else begin
      ae_reg <= ae_comb;
      af_reg <= af_comb;
    end
  end

  assign almost_empty_flag_n = cfg_reg.flag_sync ? ae_reg : ae_comb;
  assign almost_full_flag_n = cfg_reg.flag_sync ? af_reg : af_comb;

endmodule // fcf_flag_control
`default_nettype wire

/* dv/fcf_flag_control_properties.sv */
// Concurrent checks on the FIFO flag control ports
`timescale 1ns/1ps
`default_nettype none
module fcf_flag_control_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic master_clear_n,
  input wire logic partial_clear_n,
  input wire fcf_pkg::fcf_straps_t straps,
  input wire logic offset_load_select_n,
  input wire logic write_ready,
  input wire logic read_valid,
  input wire logic output_enable_n,
  input wire logic read_data_oe,
  input wire logic retransmit_request_n,
  input wire logic empty_indication_n,
  input wire fcf_pkg::fcf_cfg_t cfg
);
  // ******************************
  // Properties
  // ******************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [3:0] bus_exp;
  logic run;
  assign bus_exp = straps.write_width_strap ? (straps.read_width_strap ? 4'h8 : 4'h4)
    : (straps.read_width_strap ? 4'h2 : 4'h1);
  assign run = master_clear_n && partial_clear_n;
  oe_follow_a: assert property (read_data_oe == !output_enable_n)
    else $error("output enable not followed");
  load_block_a: assert property (!offset_load_select_n |-> !write_ready)
    else $error("memory write offered with load select low");
  clear_block_a: assert property (!run |-> !write_ready)
    else $error("write offered during clear");
  parity_cap_a: assert property (!master_clear_n |=>
    cfg.parity_interspersed == $past(straps.parity_layout_strap)) else $error("parity layout");
  flag_mode_a: assert property (!master_clear_n |=>
    cfg.flag_sync == $past(straps.flag_timing_strap)) else $error("flag timing mode");
  bus_cap_a: assert property (!master_clear_n |=> cfg.bus == $past(bus_exp))
    else $error("port widths");
  method_cap_a: assert property (!master_clear_n |=> cfg.serial_prog == !$past(offset_load_select_n))
    else $error("offset method");
  cfg_hold_a: assert property (master_clear_n && $past(master_clear_n) |-> $stable(cfg))
    else $error("configuration moved");
  retx_empty_a: assert property (run && !retransmit_request_n |=> !empty_indication_n)
    else $error("retransmit did not force empty");
  clear_empty_a: assert property (!master_clear_n |=> !empty_indication_n && !read_valid)
    else $error("clear left data");
  cover property (run && !retransmit_request_n);
  cover property (run && !offset_load_select_n);
  cover property (!write_ready && read_valid);
endmodule // fcf_flag_control_chk
bind fcf_flag_control fcf_flag_control_chk i_chk (
  .clk_sys, .reset, .master_clear_n, .partial_clear_n, .straps, .offset_load_select_n,
  .write_ready, .read_valid, .output_enable_n, .read_data_oe, .retransmit_request_n,
  .empty_indication_n, .cfg
);
`default_nettype wire

/* dv/fcf_sys_model.sv */
// System-side model that writes and reads the FIFO
`timescale 1ns/1ps
`default_nettype none
`include "fcf_map.svh"
module fcf_sys_model (
  input wire logic clk_sys,
  input wire logic write_ready,
  input wire logic read_valid,
  input wire logic [`FCF_DATA_W-1:0] read_data,
  output logic write_en,
  output logic [`FCF_DATA_W-1:0] write_data,
  output logic read_en,
  output logic read_ready
);
  // ******************************
  // Transfers
  // ******************************
  initial begin
    write_en = 1'b0;
    write_data = '0;
    read_en = 1'b0;
    read_ready = 1'b0;
  end
  // Blind writes target the offset registers, which never raise ready
  task automatic push(input logic [`FCF_DATA_W-1:0] d, input bit blind, output bit ok);
    int n;
    @(posedge clk_sys);
    write_en <= 1'b1;
    write_data <= d;
    for (n = 0; !blind && n < 64; n++) begin
      @(negedge clk_sys);
      if (write_ready) break;
    end
    ok = n < 64;
    @(posedge clk_sys);
    write_en <= 1'b0;
    write_data <= ~d;
  endtask
  task automatic pull(input int stall, output logic [`FCF_DATA_W-1:0] d, output bit ok);
    int n;
    @(posedge clk_sys);
    read_en <= 1'b1;
    @(posedge clk_sys);
    read_en <= 1'b0;
    repeat (stall) @(posedge clk_sys);
    read_ready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk_sys);
      if (read_valid) break;
    end
    d = read_data;
    ok = n < 64;
    @(posedge clk_sys);
    read_ready <= 1'b0;
  endtask
endmodule // fcf_sys_model
`default_nettype wire

/* dv/fcf_flag_control_bench.sv */
// Self-checking testbench for the FIFO flag control block
`timescale 1ns/1ps
`default_nettype none
`include "fcf_map.svh"
module fcf_flag_control_bench;
  logic clk_sys = 1'b0, reset = 1'b1, master_clear_n = 1'b1, partial_clear_n = 1'b1;
  logic offset_load_select_n = 1'b1, first_word_fallthrough_si = 1'b0, mark = 1'b0;
  logic offset_shift_enable_n = 1'b1, offset_shift_clock = 1'b0, output_enable_n = 1'b0;
  logic retransmit_request_n = 1'b1, write_en, read_en, read_ready, write_ready, read_valid;
  logic read_data_oe, empty_indication_n, almost_empty_flag_n, almost_full_flag_n;
  logic [`FCF_DATA_W-1:0] write_data, read_data;
  fcf_pkg::fcf_straps_t straps = '0;
  fcf_pkg::fcf_cfg_t cfg;
  int errors, compares;
  bit flag_late;
  fcf_flag_control i_dut (
    .clk_sys, .reset, .master_clear_n, .partial_clear_n, .straps, .offset_load_select_n,
    .first_word_fallthrough_si, .offset_shift_enable_n, .offset_shift_clock, .write_en,
    .write_data, .write_ready, .read_en, .read_valid, .read_ready, .read_data,
    .output_enable_n, .read_data_oe, .mark, .retransmit_request_n, .empty_indication_n,
    .almost_empty_flag_n, .almost_full_flag_n, .cfg
  );
  fcf_sys_model i_sys (
    .clk_sys, .write_ready, .read_valid, .read_data, .write_en, .write_data, .read_en,
    .read_ready
  );
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // ******************************
  // Helpers
  // ******************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic stop_on(input bit ok);
    if (!ok) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic put(input logic [17:0] d, input bit blind);
    bit ok;
    i_sys.push(d, blind, ok);
    stop_on(ok);
  endtask
  task automatic get(input int stall, input logic [17:0] exp);
    logic [17:0] d;
    bit ok;
    i_sys.pull(stall, d, ok);
    stop_on(ok);
    check(d, exp);
  endtask
  task automatic mclear(input logic [9:0] s, input logic ld);
    @(posedge clk_sys);
    straps <= s;
    offset_load_select_n <= ld;
    master_clear_n <= 1'b0;
    @(negedge clk_sys);
    check(read_data_oe, !output_enable_n);
    @(posedge clk_sys);
    master_clear_n <= 1'b1;
    offset_load_select_n <= 1'b1;
    @(negedge clk_sys);
    check({empty_indication_n, read_valid}, 2'b00);
  endtask
  task automatic fill(input int n, input int eoff, input int foff);
    for (int i = 0; i < n; i++) begin
      put(18'(256 + i), 1'b0);
      @(negedge clk_sys);
      if (flag_late) begin
        // Registered flags still show the count before this write
        check(almost_empty_flag_n, i >= eoff);
        check(almost_full_flag_n, int'(`FCF_DEPTH) - i > foff);
        @(negedge clk_sys);
      end
      check(almost_empty_flag_n, i + 1 >= eoff);
      check(almost_full_flag_n, int'(`FCF_DEPTH) - i - 1 > foff);
    end
  endtask
  task automatic pulse_rt;
    @(posedge clk_sys);
    retransmit_request_n <= 1'b0;
    @(posedge clk_sys);
    retransmit_request_n <= 1'b1;
    @(negedge clk_sys);
    check(empty_indication_n, 1'b0);
  endtask
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_straps;
    logic [3:0] bus_tab [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      output_enable_n <= i[0];
      mclear({i[0], i[1], i[0], i[1], 6'h00}, i[0]);
      check(cfg.parity_interspersed, i[0]);
      check(cfg.bus, bus_tab[i]);
      check(cfg.flag_sync, i[1]);
      check(cfg.serial_prog, !i[0]);
    end
    @(posedge clk_sys);
    straps <= 10'h000;
    partial_clear_n <= 1'b0;
    @(posedge clk_sys);
    partial_clear_n <= 1'b1;
    @(negedge clk_sys);
    check({cfg.parity_interspersed, cfg.bus}, 5'h18);
  endtask
  task automatic t_flags;
    mclear(10'h000, 1'b1);
    fill(16, 5, 5);
    check(write_ready, 1'b0);
    for (int i = 0; i < 16; i++) begin
      get(i % 3, 18'(256 + i));
    end
  endtask
  task automatic t_retx;
    mclear(10'h000, 1'b1);
    for (int i = 0; i < 4; i++) begin
      put(18'(512 + i), 1'b0);
    end
    get(0, 18'h200);
    @(posedge clk_sys);
    mark <= 1'b1;
    @(posedge clk_sys);
    mark <= 1'b0;
    get(1, 18'h201);
    get(0, 18'h202);
    pulse_rt();
    get(2, 18'h201);
    get(0, 18'h202);
    get(0, 18'h203);
    @(posedge clk_sys);
    partial_clear_n <= 1'b0;
    @(posedge clk_sys);
    partial_clear_n <= 1'b1;
    put(18'h2aa, 1'b0);
    get(0, 18'h2aa);
    pulse_rt();
    get(0, 18'h2aa);
  endtask
  task automatic t_offsets;
    mclear(10'h000, 1'b1);
    @(posedge clk_sys);
    offset_load_select_n <= 1'b0;
    put(18'h3, 1'b1);
    put(18'h2, 1'b1);
    get(0, 18'h3);
    get(0, 18'h2);
    @(negedge clk_sys);
    check(empty_indication_n, 1'b0);
    @(posedge clk_sys);
    offset_load_select_n <= 1'b1;
    fill(3, 3, 2);
  endtask
  task automatic t_serial;
    logic [9:0] v = 10'b00110_00100;
    mclear(10'h000, 1'b0);
    check(cfg.serial_prog, 1'b1);
    for (int b = 9; b >= 0; b--) begin
      @(posedge clk_sys);
      first_word_fallthrough_si <= v[b];
      offset_shift_enable_n <= 1'b0;
      offset_shift_clock <= 1'b1;
      @(posedge clk_sys);
      offset_shift_clock <= 1'b0;
    end
    @(posedge clk_sys);
    offset_shift_enable_n <= 1'b1;
    fill(6, 6, 4);
  endtask
  task automatic t_modes;
    // Narrow write port with registered flags
    mclear(10'h140, 1'b1);
    check(cfg.flag_sync, 1'b1);
    put(18'h3ffff, 1'b0);
    get(0, `FCF_MASK_X9);
    flag_late = 1'b1;
    fill(12, 5, 5);
    flag_late = 1'b0;
    // Fall-through mode with the default-select, endian, sync and zero-latency straps high
    @(posedge clk_sys);
    first_word_fallthrough_si <= 1'b1;
    mclear(10'h03f, 1'b1);
    check(cfg.fallthrough, 1'b1);
    check({cfg.little_endian, cfg.read_sync, cfg.write_sync, cfg.zero_latency}, 4'hf);
    check(cfg.default_sel, 3'h7);
    put(18'h155, 1'b0);
    repeat (2) @(negedge clk_sys);
    check({read_valid, read_data}, {1'b1, 18'h00155});
    get(0, 18'h155);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_straps();
    t_flags();
    t_retx();
    t_offsets();
    t_serial();
    t_modes();
    complete_run();
  end
endmodule // fcf_flag_control_bench
`default_nettype wire
